// File: hw/wdwt_pkg.sv
// Purpose: Shared constants and types for the windowed watchdog unit
// Assumes: 20 MHz system clock, 1.024 kHz slow oscillator clock input
// Notes:   Period codes 0x1..0xB map to 8..8192 slow cycles
package wdwt_pkg;

    localparam int unsigned SYS_CLK_HZ  = 20000000;
    localparam int unsigned SLOW_CLK_HZ = 1024;
    localparam int unsigned SYS_PER_SLOW = SYS_CLK_HZ / SLOW_CLK_HZ;

    localparam int unsigned CNT_W     = 14;
    localparam logic [3:0]  CODE_OFF  = 4'h0;
    localparam logic [3:0]  CODE_MAX  = 4'hB;
    localparam logic [13:0] BASE_CYC  = 14'h0008;
    localparam logic [13:0] RSVD_CYC  = 14'h2000;
    localparam logic [13:0] CNT_ONE   = 14'h0001;
    localparam logic [13:0] CNT_ZERO  = 14'h0000;

    // Unlock key value is arbitrary
    localparam logic [7:0]  IO_KEY     = 8'hA5;
    localparam logic [2:0]  CCP_INSTR  = 3'h4;
    localparam logic [1:0]  SYNC_LAST  = 2'h1;

    // Window in bits 7:4, period in bits 3:0
    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } wdwt_ctrl_s;

    localparam wdwt_ctrl_s CTRL_RST = 8'h00;

    typedef enum logic [1:0] {
        PH_OFF    = 2'b00,
        PH_ARM    = 2'b01,
        PH_CLOSED = 2'b11,
        PH_OPEN   = 2'b10
    } wdwt_phase_e;

    // Slow cycles for a period code; reserved codes take the longest
    function automatic logic [13:0] cycles(input logic [3:0] code);
        logic [13:0] r;
        r = RSVD_CYC;
        if (code != CODE_OFF && code <= CODE_MAX)
        begin
            r = 14'(BASE_CYC << (code - 4'h1));
        end
        return r;
    endfunction

endpackage

// File: hw/wdwt_tick.sv
// Purpose: Turns the slow oscillator clock into one-cycle ticks
// Assumes: Slow clock far slower than the system clock
// Notes:   Two-flop synchroniser, edge taken after the second flop
`timescale 1ns/100ps
module wdwt_tick (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_slow_clk,
    output logic      o_tick
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       tick_q;
    logic       tick_d;

    always_comb
    begin
        sync_d = {sync_q[1:0], i_slow_clk};
        // First flop feeds only the second
        tick_d = sync_q[1] & ~sync_q[2];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync_q <= 3'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule // wdwt_tick

// File: hw/wdwt_top.sv
// Purpose: Windowed watchdog unit with lock and timed-write guard
// Assumes: Control bits are plain ports, no register bus
// Notes:   Slow domain runs as ticks of the system clock
//
// Operation
// - Non-zero period code enables the watchdog; zero keeps it off.
// - Enabled watchdog requests reset when the period runs out.
// - Each accepted restart clears the count and starts a new period.
// - Eleven period choices from 8 ms to 8 s of slow clock.
// - Zero window code means normal mode, non-zero means window mode.
// - Restart during the closed period requests reset at once.
// - Open period follows closed period; total is their sum.
// - New window mode or debug exit: closed period starts at first restart.
// - Restart crosses in one to two slow cycles; repeats meanwhile ignored.
// - While locked, control writes are rejected.
// - Lock can only be written to one; cleared only in debug mode.
// - Fuse-enabled boot configuration sets the lock automatically.
// - Counter is timed by the 1.024 kHz slow oscillator clock.
// - Counting goes on in every sleep mode while the oscillator runs.
// - Debug halt stops counting and clears the counter.
// - After debug halt in window mode, a plain normal time-out runs.
// - Sync flag stands while a control write crosses to the slow side.
// - Protected writes without a valid unlock leave contents unchanged.
// - Period, window and lock are guarded by the I/O register key.
// - Codes 0x1..0xB give 8..8192 cycles, doubling; zero is off.
// - In window mode period sets open time, window sets closed time.
// - Window field in bits 7:4, period field in bits 3:0.
`timescale 1ns/100ps
module wdwt_top (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_slow_clk,
    input  wire logic [7:0]       i_fuse_cfg,
    input  wire logic             i_key_wr,
    input  wire logic [7:0]       i_key_data,
    input  wire logic             i_instr,
    input  wire logic             i_wr_ctrl,
    input  wire logic [7:0]       i_wr_data,
    input  wire logic             i_wr_lock,
    input  wire logic             i_lock_data,
    input  wire logic             i_restart,
    input  wire logic             i_debug_mode,
    input  wire logic             i_debug_halt,
    input  wire logic             i_cause_clr,
    output wdwt_pkg::wdwt_ctrl_s  o_ctrl,
    output logic                  o_lock,
    output logic                  o_sync_pending,
    output logic                  o_reset_req,
    output logic                  o_reset_cause
);
    // CPU-side state
    wdwt_pkg::wdwt_ctrl_s ctrl_q;
    wdwt_pkg::wdwt_ctrl_s ctrl_d;
    logic                 lock_q;
    logic                 lock_d;
    logic                 boot_q;
    logic                 boot_d;
    logic [2:0]           ccp_q;
    logic [2:0]           ccp_d;
    logic                 unlock;
    logic                 wr_ok;
    logic                 load_cfg;

    // Slow-side state
    wdwt_pkg::wdwt_ctrl_s act_q;
    wdwt_pkg::wdwt_ctrl_s act_d;
    logic                 cpend_q;
    logic                 cpend_d;
    logic [1:0]           ctick_q;
    logic [1:0]           ctick_d;
    logic                 rpend_q;
    logic                 rpend_d;
    logic [1:0]           rtick_q;
    logic [1:0]           rtick_d;
    wdwt_pkg::wdwt_phase_e phase_q;
    wdwt_pkg::wdwt_phase_e phase_d;
    logic [13:0]          cnt_q;
    logic [13:0]          cnt_d;
    logic                 rreq_q;
    logic                 rreq_d;
    logic                 cause_q;
    logic                 cause_d;
    logic                 tick;
    logic                 cfg_done;
    logic                 rst_done;
    logic                 fire;
    logic [13:0]          cnt_inc;

    wdwt_tick u_tick (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_slow_clk (i_slow_clk),
        .o_tick     (tick)
    );

    always_comb
    begin
        boot_d = 1'b1;
        ctrl_d = ctrl_q;
        lock_d = lock_q;
        ccp_d  = ccp_q;
        unlock = (ccp_q != 3'h0);
        // Key opens a window of four instructions
        if (i_key_wr && i_key_data == wdwt_pkg::IO_KEY)
        begin
            ccp_d = wdwt_pkg::CCP_INSTR;
        end
        else if (unlock && i_instr)
        begin
            ccp_d = ccp_q - 3'h1;
        end
        wr_ok = i_wr_ctrl && unlock && !lock_q && boot_q;
        load_cfg = wr_ok || !boot_q;
        if (!boot_q)
        begin
            // Fuse taken on the first edge after reset release
            ctrl_d = i_fuse_cfg;
            lock_d = (i_fuse_cfg[3:0] != wdwt_pkg::CODE_OFF);
        end
        else
        begin
            if (wr_ok)
            begin
                ctrl_d = i_wr_data;
            end
            if (i_wr_lock && unlock)
            begin
                if (i_lock_data)
                begin
                    lock_d = 1'b1;
                end
                else if (i_debug_mode)
                begin
                    lock_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_q <= wdwt_pkg::CTRL_RST;
            lock_q <= 1'b0;
            boot_q <= 1'b0;
            ccp_q  <= 3'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            lock_q <= lock_d;
            boot_q <= boot_d;
            ccp_q  <= ccp_d;
        end
    end

    always_comb
    begin
        act_d    = act_q;
        cpend_d  = cpend_q;
        ctick_d  = ctick_q;
        rpend_d  = rpend_q;
        rtick_d  = rtick_q;
        phase_d  = phase_q;
        cnt_d    = cnt_q;
        fire     = 1'b0;
        cfg_done = 1'b0;
        rst_done = 1'b0;
        cnt_inc  = 14'(cnt_q + wdwt_pkg::CNT_ONE);
        // Config crossing; a rewrite restarts it
        if (load_cfg)
        begin
            cpend_d = 1'b1;
            ctick_d = 2'h0;
        end
        else if (cpend_q && tick)
        begin
            if (ctick_q == wdwt_pkg::SYNC_LAST)
            begin
                cpend_d  = 1'b0;
                cfg_done = 1'b1;
            end
            else
            begin
                ctick_d = 2'(ctick_q + 2'h1);
            end
        end
        // Restart crossing, repeats dropped while pending
        if (!rpend_q)
        begin
            rpend_d = i_restart;
            rtick_d = 2'h0;
        end
        else if (tick)
        begin
            if (rtick_q == wdwt_pkg::SYNC_LAST)
            begin
                rpend_d  = 1'b0;
                rst_done = 1'b1;
            end
            else
            begin
                rtick_d = 2'(rtick_q + 2'h1);
            end
        end
        if (cfg_done)
        begin
            act_d = ctrl_q;
            cnt_d = wdwt_pkg::CNT_ZERO;
            if (ctrl_q.period == wdwt_pkg::CODE_OFF)
            begin
                phase_d = wdwt_pkg::PH_OFF;
            end
            else if (ctrl_q.window == wdwt_pkg::CODE_OFF)
            begin
                phase_d = wdwt_pkg::PH_OPEN;
            end
            else if (act_q.window == wdwt_pkg::CODE_OFF ||
                     phase_q == wdwt_pkg::PH_OFF)
            begin
                phase_d = wdwt_pkg::PH_ARM;
            end
        end
        else if (i_debug_halt)
        begin
            // Halt clears count; resume runs a normal time-out first
            cnt_d = wdwt_pkg::CNT_ZERO;
            if (act_q.period == wdwt_pkg::CODE_OFF)
            begin
                phase_d = wdwt_pkg::PH_OFF;
            end
            else if (act_q.window != wdwt_pkg::CODE_OFF)
            begin
                phase_d = wdwt_pkg::PH_ARM;
            end
            else
            begin
                phase_d = wdwt_pkg::PH_OPEN;
            end
        end
        else
        begin
            if (tick)
            begin
                case (phase_q)
                    wdwt_pkg::PH_ARM,
                    wdwt_pkg::PH_OPEN:
                    begin
                        if (cnt_inc >= wdwt_pkg::cycles(act_q.period))
                        begin
                            fire = 1'b1;
                        end
                        cnt_d = cnt_inc;
                    end
                    wdwt_pkg::PH_CLOSED:
                    begin
                        if (cnt_inc >= wdwt_pkg::cycles(act_q.window))
                        begin
                            phase_d = wdwt_pkg::PH_OPEN;
                            cnt_d   = wdwt_pkg::CNT_ZERO;
                        end
                        else
                        begin
                            cnt_d = cnt_inc;
                        end
                    end
                    wdwt_pkg::PH_OFF:
                    begin
                        cnt_d = wdwt_pkg::CNT_ZERO;
                    end
                    default:
                    begin
                        phase_d = wdwt_pkg::PH_OFF;
                    end
                endcase
            end
            if (rst_done && phase_q != wdwt_pkg::PH_OFF)
            begin
                cnt_d = wdwt_pkg::CNT_ZERO;
                if (phase_q == wdwt_pkg::PH_CLOSED)
                begin
                    fire = 1'b1;
                end
                else if (act_q.window != wdwt_pkg::CODE_OFF)
                begin
                    phase_d = wdwt_pkg::PH_CLOSED;
                end
                else
                begin
                    fire = 1'b0;
                end
            end
            if (fire)
            begin
                cnt_d = wdwt_pkg::CNT_ZERO;
                if (act_q.window != wdwt_pkg::CODE_OFF)
                begin
                    phase_d = wdwt_pkg::PH_ARM;
                end
                else
                begin
                    phase_d = wdwt_pkg::PH_OPEN;
                end
            end
        end
        rreq_d  = fire;
        cause_d = fire | (cause_q & ~i_cause_clr);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            act_q   <= wdwt_pkg::CTRL_RST;
            cpend_q <= 1'b0;
            ctick_q <= 2'h0;
            rpend_q <= 1'b0;
            rtick_q <= 2'h0;
            phase_q <= wdwt_pkg::PH_OFF;
            cnt_q   <= 14'h0000;
            rreq_q  <= 1'b0;
            cause_q <= 1'b0;
        end
        else
        begin
            act_q   <= act_d;
            cpend_q <= cpend_d;
            ctick_q <= ctick_d;
            rpend_q <= rpend_d;
            rtick_q <= rtick_d;
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
            rreq_q  <= rreq_d;
            cause_q <= cause_d;
        end
    end

    assign o_ctrl         = ctrl_q;
    assign o_lock         = lock_q;
    assign o_sync_pending = cpend_q;
    assign o_reset_req    = rreq_q;
    assign o_reset_cause  = cause_q;

    property p_locked;
        @(posedge i_clk) disable iff (!i_rstn)
        lock_q && boot_q && i_wr_ctrl |=> $stable(ctrl_q);
    endproperty
    a_locked: assert property (p_locked)
        else $error("control changed while locked");

    property p_guard;
        @(posedge i_clk) disable iff (!i_rstn)
        boot_q && !unlock |=> $stable(ctrl_q) && (lock_q == $past(lock_q));
    endproperty
    a_guard: assert property (p_guard)
        else $error("protected state changed without unlock");

    property p_lock_sticky;
        @(posedge i_clk) disable iff (!i_rstn)
        lock_q && !i_debug_mode |=> lock_q;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock cleared outside debug");

    property p_sync_flag;
        @(posedge i_clk) disable iff (!i_rstn)
        wr_ok |=> cpend_q && (ctick_q == 2'h0);
    endproperty
    a_sync_flag: assert property (p_sync_flag)
        else $error("sync flag not raised by write");

    property p_apply;
        @(posedge i_clk) disable iff (!i_rstn)
        cfg_done && !load_cfg |=> !cpend_q && (act_q == ctrl_q);
    endproperty
    a_apply: assert property (p_apply)
        else $error("config not applied at end of sync");

    property p_early;
        @(posedge i_clk) disable iff (!i_rstn)
        rst_done && !cfg_done && !i_debug_halt &&
        phase_q == wdwt_pkg::PH_CLOSED |=> rreq_q ##1 !rreq_q;
    endproperty
    a_early: assert property (p_early)
        else $error("early restart did not pulse reset");

    property p_off;
        @(posedge i_clk) disable iff (!i_rstn)
        act_q.period == wdwt_pkg::CODE_OFF |-> phase_q == wdwt_pkg::PH_OFF;
    endproperty
    a_off: assert property (p_off)
        else $error("running with period off");

    property p_halt;
        @(posedge i_clk) disable iff (!i_rstn)
        i_debug_halt && !cfg_done |=> cnt_q == 14'h0000 && !rreq_q;
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter kept during debug halt");

    property p_ignore;
        @(posedge i_clk) disable iff (!i_rstn)
        rpend_q && !rst_done |=> rpend_q;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("restart crossing lost");

    property p_timeout;
        @(posedge i_clk) disable iff (!i_rstn)
        tick && !cfg_done && !i_debug_halt && !rst_done &&
        phase_q == wdwt_pkg::PH_OPEN &&
        cnt_inc >= wdwt_pkg::cycles(act_q.period) |=> rreq_q && cause_q;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out did not request reset");
endmodule // wdwt_top

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the windowed watchdog unit
// Assumes: Slow clock sped up to 16 system cycles per period
// Notes:   Expected counts use code 1, eight slow cycles per period
`timescale 1ns/100ps
module tb_top;
    localparam int TICK  = 16;
    localparam int LIMIT = 8000;

    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 slow_clk = 1'b0;
    logic                 dbg_mode = 1'b0;
    logic                 dbg_halt = 1'b0;
    logic [7:0]           fuse = 8'h00;
    logic [7:0]           req_cnt = 8'h00;
    logic [7:0]           base;
    int                   bad_count = 0;
    int                   checks = 0;
    int                   cyc = 0;
    wire logic            key_wr, instr, wr_ctrl, wr_lock, lock_data;
    wire logic            restart, cause_clr, lock, pend, req, cause;
    wire logic [7:0]      key_data, wr_data;
    wdwt_pkg::wdwt_ctrl_s ctrl;

    always #25 clk = ~clk;
    // Slow edges land on falling system edges, never on rising ones
    always #400 slow_clk = ~slow_clk;

    wdwt_cpu_model cpu (
        .i_clk(clk), .i_sync_pending(pend), .o_key_wr(key_wr),
        .o_key_data(key_data), .o_instr(instr), .o_wr_ctrl(wr_ctrl),
        .o_wr_data(wr_data), .o_wr_lock(wr_lock),
        .o_lock_data(lock_data), .o_restart(restart),
        .o_cause_clr(cause_clr)
    );

    wdwt_top dut (
        .i_clk(clk), .i_rstn(rstn), .i_slow_clk(slow_clk),
        .i_fuse_cfg(fuse), .i_key_wr(key_wr), .i_key_data(key_data),
        .i_instr(instr), .i_wr_ctrl(wr_ctrl), .i_wr_data(wr_data),
        .i_wr_lock(wr_lock), .i_lock_data(lock_data),
        .i_restart(restart), .i_debug_mode(dbg_mode),
        .i_debug_halt(dbg_halt), .i_cause_clr(cause_clr),
        .o_ctrl(ctrl), .o_lock(lock), .o_sync_pending(pend),
        .o_reset_req(req), .o_reset_cause(cause)
    );

    // High cycles counted, so a stuck-high request shows as too many
    always @(posedge clk)
    begin
        if (req === 1'b1)
        begin
            req_cnt <= req_cnt + 8'h01;
        end
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge clk);
        #1;
    endtask

    task automatic wait_pend();
        int n;
        for (n = 0; n < 8 * TICK && pend !== 1'b0; n++)
        begin
            settle();
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        #1 cmp(ctrl, 8'h00);
        rstn = 1'b1;
        settle();
        wait_pend();
        cpu.wr_ctrl(8'h01);
        settle();
        cmp(ctrl, 8'h00);
        cpu.key(8'h5A);
        cpu.wr_ctrl(8'h01);
        settle();
        cmp(ctrl, 8'h00);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.instr(4);
        cpu.wr_ctrl(8'h01);
        settle();
        cmp(ctrl, 8'h00);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_ctrl(8'h01);
        settle();
        cmp(ctrl, 8'h01);
        cmp({7'h00, pend}, 8'h01);
        wait_pend();
        cmp({7'h00, pend}, 8'h00);
        base = req_cnt;
        ticks(5);
        cmp(req_cnt - base, 8'h00);
        ticks(5);
        cmp(req_cnt - base, 8'h01);
        cmp({7'h00, cause}, 8'h01);
        cpu.cause_clr();
        settle();
        cmp({7'h00, cause}, 8'h00);
        base = req_cnt;
        repeat (6)
        begin
            cpu.restart();
            ticks(4);
        end
        cmp(req_cnt - base, 8'h00);
        // Closed 8, open 8; the doubled restart must not count twice
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_ctrl(8'h11);
        settle();
        wait_pend();
        base = req_cnt;
        // Second restart lands well inside the first crossing
        cpu.restart();
        cpu.restart();
        ticks(5);
        cmp(req_cnt - base, 8'h00);
        cpu.restart();
        ticks(4);
        cmp(req_cnt - base, 8'h01);
        dbg_halt = 1'b1;
        ticks(20);
        cmp(req_cnt - base, 8'h01);
        dbg_halt = 1'b0;
        base = req_cnt;
        ticks(5);
        cmp(req_cnt - base, 8'h00);
        ticks(5);
        cmp(req_cnt - base, 8'h01);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_ctrl(8'h00);
        settle();
        wait_pend();
        base = req_cnt;
        ticks(20);
        cmp(req_cnt - base, 8'h00);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_lock(1'b1);
        settle();
        cmp({7'h00, lock}, 8'h01);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_ctrl(8'h03);
        settle();
        cmp(ctrl, 8'h00);
        cmp({7'h00, pend}, 8'h00);
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_lock(1'b0);
        settle();
        cmp({7'h00, lock}, 8'h01);
        dbg_mode = 1'b1;
        cpu.key(wdwt_pkg::IO_KEY);
        cpu.wr_lock(1'b0);
        settle();
        cmp({7'h00, lock}, 8'h00);
        dbg_mode = 1'b0;
        fuse = 8'h32;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        settle();
        settle();
        cmp(ctrl, 8'h32);
        cmp({7'h00, lock}, 8'h01);
        give_verdict();
    end
endmodule // tb_top

// File: verif/wdwt_cpu_model.sv
// Purpose: CPU side issuing unlock keys, protected writes and restarts
// Assumes: Design samples strobes on the rising edge of i_clk
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/100ps
module wdwt_cpu_model (
    input  wire logic  i_clk,
    input  wire logic  i_sync_pending,
    output logic       o_key_wr,
    output logic [7:0] o_key_data,
    output logic       o_instr,
    output logic       o_wr_ctrl,
    output logic [7:0] o_wr_data,
    output logic       o_wr_lock,
    output logic       o_lock_data,
    output logic       o_restart,
    output logic       o_cause_clr
);
    initial
    begin
        o_key_wr    = 1'b0;
        o_key_data  = 8'h00;
        o_instr     = 1'b0;
        o_wr_ctrl   = 1'b0;
        o_wr_data   = 8'h00;
        o_wr_lock   = 1'b0;
        o_lock_data = 1'b0;
        o_restart   = 1'b0;
        o_cause_clr = 1'b0;
    end

    // Key first; caller then writes within four instructions
    task automatic key(input logic [7:0] k);
        @(posedge i_clk);
        #1 o_key_wr = 1'b1;
        o_key_data = k;
        @(posedge i_clk);
        #1 o_key_wr = 1'b0;
        o_key_data = ~k;
    endtask

    // One instruction per cycle held high
    task automatic instr(input int n);
        @(posedge i_clk);
        #1 o_instr = 1'b1;
        repeat (n) @(posedge i_clk);
        #1 o_instr = 1'b0;
    endtask

    // Waits up to 2000 cycles for the sync flag to clear before writing
    task automatic wr_ctrl(input logic [7:0] d);
        int n;
        for (n = 0; n < 2000 && i_sync_pending !== 1'b0; n++)
        begin
            @(posedge i_clk);
        end
        @(posedge i_clk);
        #1 o_wr_ctrl = 1'b1;
        o_wr_data = d;
        @(posedge i_clk);
        #1 o_wr_ctrl = 1'b0;
        o_wr_data = ~d;
    endtask

    task automatic wr_lock(input logic b);
        @(posedge i_clk);
        #1 o_wr_lock = 1'b1;
        o_lock_data = b;
        @(posedge i_clk);
        #1 o_wr_lock = 1'b0;
        o_lock_data = ~b;
    endtask

    task automatic restart();
        @(posedge i_clk);
        #1 o_restart = 1'b1;
        @(posedge i_clk);
        #1 o_restart = 1'b0;
    endtask

    task automatic cause_clr();
        @(posedge i_clk);
        #1 o_cause_clr = 1'b1;
        @(posedge i_clk);
        #1 o_cause_clr = 1'b0;
    endtask
endmodule // wdwt_cpu_model
